// *** rtl/dfa_config_regs.v ***
// demodulation filter, ask threshold and afc configuration register bank
// ============================================================
`timescale 1ns/1ps
`include "dfa_defines.vh"
module dfa_config_regs (
	input wire clk, // system clock, 200 MHz
	input wire nrst, // synchronous reset, active low
	input wire [7:0] reg_addr, // register address
	input wire [7:0] reg_wdata, // write data
	input wire reg_wr, // write strobe, one cycle
	input wire reg_rd, // read strobe, one cycle
	output reg [7:0] reg_rdata, // read data, held until next read
	output reg reg_rvalid, // read data valid, one cycle
	input wire ask_mode, // receiver in ask demodulation
	input wire preamble_det, // preamble detected pulse
	input wire rx_restart, // new reception pulse
	output wire low_delay_buffer_sel, // low-delay output buffer chosen
	output wire filter_bandwidth_boost, // filter bandwidth 1.67x
	output wire [2:0] rate_conv_large_step, // large rate step code
	output wire [2:0] rate_conv_small_step, // small rate step code
	output reg [3:0] rate_large_shift, // signed log2 rate factor vs default
	output reg [3:0] rate_small_denom, // denominator of 8/(8+n)
	output reg low_delay_buffer_sel_conflict, // low-delay chosen with illegal rate steps
	output wire [7:0] threshold_lower_bound, // signed lower bound
	output reg lower_bound_conflict, // lower bound above zero
	output wire [1:0] peak_hold_time, // peak-hold code
	output reg [3:0] peak_hold_mult, // discharge time multiplier
	output wire [4:0] threshold_time_const, // time constant
	output wire threshold_method_sel, // threshold method bit
	output reg adaptive_peak_detector, // peak detector method active
	output reg precharged_lowpass, // precharged lowpass method active
	output wire threshold_filter_bw, // lowpass bandwidth doubled
	output wire [4:0] threshold_gain_const, // gain constant
	output wire [2:0] freq_offset_limit, // offset limit code n of n/7
	output reg afc_enable, // afc active
	output wire [1:0] freq_loop_gain, // loop gain code
	output reg [2:0] loop_gain_shift, // gain as left shift of quarter default
	output wire freeze_on_preamble, // freeze-after-preamble setting
	output wire afc_frozen, // correction currently frozen
	output wire afc_update_en // synthesizer correction may update
);

	wire [7:0] pdf_q;
	wire [7:0] threshold_lower_bound_q;
	wire [6:0] ath_tim_q;
	wire [6:0] ath_met_q;
	wire [4:0] afc_loop_q;
	wire [6:0] afc_frz_q;
	wire [7:0] rv_pdf;
	wire [7:0] rv_lb;
	wire [7:0] rv_tim;
	wire [7:0] rv_met;
	wire [7:0] rv_loop;
	wire [7:0] rv_frz;
	wire h_pdf;
	wire h_lb;
	wire h_tim;
	wire h_met;
	wire h_loop;
	wire h_frz;
	reg [7:0] next_rdata;

	// ============================================================
	// register storage
	dfa_cfg_reg #(
		.ADDR(`DFA_ADDR_POST_DEMOD_FILTER_CFG),
		.WIDTH(8),
		.RESET_VAL(`DFA_RST_POST_DEMOD_FILTER_CFG)
	) u_pdf (
		.clk(clk),
		.nrst(nrst),
		.wr_addr(reg_addr),
		.wr_data(reg_wdata),
		.wr_en(reg_wr),
		.value(pdf_q),
		.rd_view(rv_pdf),
		.hit(h_pdf)
	);

	dfa_cfg_reg #(
		.ADDR(`DFA_ADDR_THRESHOLD_LOWER_BOUND),
		.WIDTH(8),
		.RESET_VAL(`DFA_RST_THRESHOLD_LOWER_BOUND)
	) u_threshold_lower_bound (
		.clk(clk),
		.nrst(nrst),
		.wr_addr(reg_addr),
		.wr_data(reg_wdata),
		.wr_en(reg_wr),
		.value(threshold_lower_bound_q),
		.rd_view(rv_lb),
		.hit(h_lb)
	);

	dfa_cfg_reg #(
		.ADDR(`DFA_ADDR_ATH_TIMING),
		.WIDTH(7),
		.RESET_VAL(`DFA_RST_ATH_TIMING)
	) u_ath_tim (
		.clk(clk),
		.nrst(nrst),
		.wr_addr(reg_addr),
		.wr_data(reg_wdata),
		.wr_en(reg_wr),
		.value(ath_tim_q),
		.rd_view(rv_tim),
		.hit(h_tim)
	);

	dfa_cfg_reg #(
		.ADDR(`DFA_ADDR_ATH_METHOD),
		.WIDTH(7),
		.RESET_VAL(`DFA_RST_ATH_METHOD)
	) u_ath_met (
		.clk(clk),
		.nrst(nrst),
		.wr_addr(reg_addr),
		.wr_data(reg_wdata),
		.wr_en(reg_wr),
		.value(ath_met_q),
		.rd_view(rv_met),
		.hit(h_met)
	);

	dfa_cfg_reg #(
		.ADDR(`DFA_ADDR_AFC_LOOP),
		.WIDTH(5),
		.RESET_VAL(`DFA_RST_AFC_LOOP)
	) u_afc_loop (
		.clk(clk),
		.nrst(nrst),
		.wr_addr(reg_addr),
		.wr_data(reg_wdata),
		.wr_en(reg_wr),
		.value(afc_loop_q),
		.rd_view(rv_loop),
		.hit(h_loop)
	);

	// reserved bits 5:0 are stored so they read back as written
	dfa_cfg_reg #(
		.ADDR(`DFA_ADDR_AFC_FREEZE),
		.WIDTH(7),
		.RESET_VAL(`DFA_RST_AFC_FREEZE)
	) u_afc_frz (
		.clk(clk),
		.nrst(nrst),
		.wr_addr(reg_addr),
		.wr_data(reg_wdata),
		.wr_en(reg_wr),
		.value(afc_frz_q),
		.rd_view(rv_frz),
		.hit(h_frz)
	);

	// ============================================================
	// field views
	assign low_delay_buffer_sel = pdf_q[`DFA_LOW_DELAY_BUFFER_SEL_BIT];
	assign filter_bandwidth_boost = pdf_q[`DFA_FILTER_BANDWIDTH_BOOST_BIT];
	assign rate_conv_large_step = pdf_q[`DFA_RATE_CONV_LARGE_STEP_MSB:`DFA_RATE_CONV_LARGE_STEP_LSB];
	assign rate_conv_small_step = pdf_q[`DFA_RATE_CONV_SMALL_STEP_MSB:`DFA_RATE_CONV_SMALL_STEP_LSB];
	assign threshold_lower_bound = threshold_lower_bound_q;
	assign peak_hold_time = ath_tim_q[`DFA_PEAK_HOLD_MSB:`DFA_PEAK_HOLD_LSB];
	assign threshold_time_const = ath_tim_q[`DFA_TIME_CONST_MSB:`DFA_TIME_CONST_LSB];
	assign threshold_method_sel = ath_met_q[`DFA_METHOD_BIT];
	assign threshold_filter_bw = ath_met_q[`DFA_TH_BW_BIT];
	assign threshold_gain_const = ath_met_q[`DFA_GAIN_CONST_MSB:`DFA_GAIN_CONST_LSB];
	assign freq_offset_limit = afc_loop_q[`DFA_OFFSET_LIM_MSB:`DFA_OFFSET_LIM_LSB];
	assign freq_loop_gain = afc_loop_q[`DFA_LOOP_GAIN_MSB:`DFA_LOOP_GAIN_LSB];
	assign freeze_on_preamble = afc_frz_q[`DFA_FREEZE_BIT];

	// ============================================================
	// decoded controls, registered one cycle behind the fields
	always @(posedge clk) begin
		if (!nrst) begin
			rate_large_shift <= 4'h0;
			rate_small_denom <= `DFA_SMALL_DENOM_BASE;
			low_delay_buffer_sel_conflict <= 1'b0;
			lower_bound_conflict <= 1'b0;
			peak_hold_mult <= 4'h1;
			adaptive_peak_detector <= 1'b0;
			precharged_lowpass <= 1'b1;
			afc_enable <= 1'b0;
			loop_gain_shift <= 3'h2;
		end else begin
			// +2 means 4x, 0 default, -5 means 1/32
			rate_large_shift <= {1'b0, `DFA_RATE_CONV_LARGE_STEP_DEFAULT} - {1'b0, rate_conv_large_step};
			rate_small_denom <= `DFA_SMALL_DENOM_BASE + {1'b0, rate_conv_small_step};
			// flagged only, not blocked: the buffer choice stays as written
			low_delay_buffer_sel_conflict <= low_delay_buffer_sel &&
				!((rate_conv_large_step >= `DFA_RATE_CONV_LARGE_STEP_LOWDLY_MIN) ||
				((rate_conv_large_step == `DFA_RATE_CONV_LARGE_STEP_DEFAULT) &&
				!rate_conv_small_step[0]));
			lower_bound_conflict <= !threshold_lower_bound_q[7] && (threshold_lower_bound_q != 8'h00);
			peak_hold_mult <= 4'h1 << peak_hold_time;
			adaptive_peak_detector <= threshold_method_sel;
			precharged_lowpass <= !threshold_method_sel;
			afc_enable <= (freq_offset_limit != 3'h0);
			loop_gain_shift <= {1'b0, freq_loop_gain};
		end
	end

	// ============================================================
	// afc freeze
	dfa_afc_gate u_afc_gate (
		.clk(clk),
		.nrst(nrst),
		.freeze_en(freeze_on_preamble),
		.ask_mode(ask_mode),
		.afc_on(freq_offset_limit != 3'h0),
		.preamble_det(preamble_det),
		.rx_restart(rx_restart),
		.frozen(afc_frozen),
		.update_en(afc_update_en)
	);

	// ============================================================
	// read-back; unmapped addresses read zero
	always @* begin
		next_rdata = 8'h00;
		case (1'b1)
			h_pdf: next_rdata = rv_pdf;
			h_lb: next_rdata = rv_lb;
			h_tim: next_rdata = rv_tim;
			h_met: next_rdata = rv_met;
			h_loop: next_rdata = rv_loop;
			h_frz: next_rdata = rv_frz;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

endmodule // dfa_config_regs

// *** rtl/dfa_defines.vh ***
// register offsets, field positions and reset values of the demod filter / afc config bank
`ifndef DFA_DEFINES_VH
`define DFA_DEFINES_VH

// ============================================================
// register offsets
`define DFA_ADDR_POST_DEMOD_FILTER_CFG 8'h03
`define DFA_ADDR_THRESHOLD_LOWER_BOUND 8'h04
`define DFA_ADDR_ATH_TIMING 8'h05
`define DFA_ADDR_ATH_METHOD 8'h06
`define DFA_ADDR_AFC_LOOP 8'h07
`define DFA_ADDR_AFC_FREEZE 8'h08

// ============================================================
// reset values
`define DFA_RST_POST_DEMOD_FILTER_CFG 8'h10
`define DFA_RST_THRESHOLD_LOWER_BOUND 8'h00
`define DFA_RST_ATH_TIMING 7'h10
`define DFA_RST_ATH_METHOD 7'h0F
`define DFA_RST_AFC_LOOP 5'h02
`define DFA_RST_AFC_FREEZE 7'h00

// ============================================================
// field positions
`define DFA_LOW_DELAY_BUFFER_SEL_BIT 7
`define DFA_FILTER_BANDWIDTH_BOOST_BIT 6
`define DFA_RATE_CONV_LARGE_STEP_MSB 5
`define DFA_RATE_CONV_LARGE_STEP_LSB 3
`define DFA_RATE_CONV_SMALL_STEP_MSB 2
`define DFA_RATE_CONV_SMALL_STEP_LSB 0
`define DFA_PEAK_HOLD_MSB 6
`define DFA_PEAK_HOLD_LSB 5
`define DFA_TIME_CONST_MSB 4
`define DFA_TIME_CONST_LSB 0
`define DFA_METHOD_BIT 6
`define DFA_TH_BW_BIT 5
`define DFA_GAIN_CONST_MSB 4
`define DFA_GAIN_CONST_LSB 0
`define DFA_OFFSET_LIM_MSB 4
`define DFA_OFFSET_LIM_LSB 2
`define DFA_LOOP_GAIN_MSB 1
`define DFA_LOOP_GAIN_LSB 0
`define DFA_FREEZE_BIT 6

// ============================================================
// decode constants
`define DFA_RATE_CONV_LARGE_STEP_DEFAULT 3'h2
`define DFA_RATE_CONV_LARGE_STEP_LOWDLY_MIN 3'h3
`define DFA_SMALL_DENOM_BASE 4'h8

`endif

// *** rtl/dfa_cfg_reg.v ***
// one software-writable configuration register with read-back
`timescale 1ns/1ps
module dfa_cfg_reg #(
	parameter [7:0] ADDR = 8'h00,
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input wire clk, // system clock
	input wire nrst, // synchronous reset, active low
	input wire [7:0] wr_addr, // register address
	input wire [7:0] wr_data, // write data
	input wire wr_en, // write strobe
	output reg [WIDTH-1:0] value, // stored field bits
	output wire [7:0] rd_view, // value in low bits, upper bits zero
	output wire hit // address matches this register
);

	assign hit = (wr_addr == ADDR);
	generate
		if (WIDTH < 8) begin : g_pad
			assign rd_view = {{(8-WIDTH){1'b0}}, value};
		end else begin : g_full
			assign rd_view = value[7:0];
		end
	endgenerate

	// ============================================================
	// storage
	always @(posedge clk) begin
		if (!nrst) begin
			value <= RESET_VAL;
		end else if (wr_en && hit) begin
			value <= wr_data[WIDTH-1:0];
		end
	end

endmodule // dfa_cfg_reg

// *** rtl/dfa_afc_gate.v ***
// afc freeze-after-preamble tracking and update gating
`timescale 1ns/1ps
module dfa_afc_gate (
	input wire clk, // system clock
	input wire nrst, // synchronous reset, active low
	input wire freeze_en, // freeze_on_preamble setting
	input wire ask_mode, // receiver in ask demodulation
	input wire afc_on, // offset limit non-zero
	input wire preamble_det, // preamble found, one-cycle pulse
	input wire rx_restart, // new reception, releases the freeze
	output reg frozen, // correction held after preamble
	output reg update_en // synthesizer correction may update
);

	reg next_frozen;

	// ============================================================
	// freeze state: a preamble in an rx_restart cycle still freezes
	always @* begin
		next_frozen = frozen;
		if (preamble_det && freeze_en && !ask_mode) begin
			next_frozen = 1'b1;
		end else if (rx_restart || !freeze_en || ask_mode) begin
			next_frozen = 1'b0;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			frozen <= 1'b0;
			update_en <= 1'b0;
		end else begin
			frozen <= next_frozen;
			update_en <= afc_on && !next_frozen;
		end
	end

endmodule // dfa_afc_gate

// *** test/dfa_config_regs_checker.sv ***
// assertion checker bound to the demod filter / afc config bank
`timescale 1ns/1ps
module dfa_config_regs_checker (
	input wire clk, // clock
	input wire nrst, // reset
	input wire [7:0] reg_addr, // address
	input wire [7:0] reg_wdata, // data
	input wire reg_wr, // write
	input wire reg_rd, // read
	input wire reg_rvalid, // valid
	input wire ask_mode, // ask
	input wire preamble_det, // preamble
	input wire freeze_on_preamble, // freeze bit
	input wire afc_frozen, // frozen
	input wire afc_update_en, // may update
	input wire lower_bound_conflict, // bad bound
	input wire [3:0] rate_large_shift, // shift
	input wire [3:0] rate_small_denom, // denom
	input wire [3:0] peak_hold_mult, // mult
	input wire adaptive_peak_detector, // peak
	input wire precharged_lowpass, // lowpass
	input wire afc_enable, // afc on
	input wire [2:0] loop_gain_shift // gain
);
	wire w3 = reg_wr && reg_addr == 8'h03;
	wire w4 = reg_wr && reg_addr == 8'h04;
	wire w5 = reg_wr && reg_addr == 8'h05;
	wire w6 = reg_wr && reg_addr == 8'h06;
	wire w7 = reg_wr && reg_addr == 8'h07;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ============================================================
	// decodes land two edges after the write
	a_read_answered: assert property (reg_rd |=> reg_rvalid)
		else $error("read unanswered");
	a_large_shift: assert property (w3 |=> ##1
		rate_large_shift == 4'h2 - {1'b0, $past(reg_wdata[5:3], 2)}) else $error("shift");
	a_small_denom: assert property (w3 |=> ##1
		rate_small_denom == 4'h8 + {1'b0, $past(reg_wdata[2:0], 2)}) else $error("denom");
	a_bound_flag: assert property (w4 |=> ##1 lower_bound_conflict ==
		(!$past(reg_wdata[7], 2) && $past(reg_wdata, 2) != 8'h00)) else $error("bound");
	a_peak_mult: assert property (w5 |=> ##1
		peak_hold_mult == 4'h1 << $past(reg_wdata[6:5], 2)) else $error("peak");
	a_method_pair: assert property (w6 |=> ##1 adaptive_peak_detector ==
		$past(reg_wdata[6], 2) && precharged_lowpass != adaptive_peak_detector) else $error("method");
	a_afc_decode: assert property (w7 |=> ##1 afc_enable ==
		($past(reg_wdata[4:2], 2) != 3'h0) && loop_gain_shift == {1'b0, $past(reg_wdata[1:0], 2)})
		else $error("afc decode");
	a_freeze_set: assert property (preamble_det && freeze_on_preamble && !ask_mode
		|=> afc_frozen && !afc_update_en) else $error("no freeze");
	a_ask_unfrozen: assert property (ask_mode |=> !afc_frozen)
		else $error("frozen in ask");
	c_freeze: cover property (afc_frozen ##1 !afc_frozen);
	c_bound: cover property (lower_bound_conflict);
	c_read: cover property (reg_rd ##1 reg_rvalid);
endmodule // dfa_config_regs_checker
bind dfa_config_regs dfa_config_regs_checker chk_i (.*);

// *** test/dfa_host.sv ***
// host model driving the config bank strobe port
`timescale 1ns/1ps
module dfa_host (
	input wire clk, // clock
	input wire [7:0] reg_rdata, // read data
	input wire reg_rvalid, // valid
	output reg [7:0] reg_addr = 8'h00, // address
	output reg [7:0] reg_wdata = 8'h00, // data
	output reg reg_wr = 1'b0, // write
	output reg reg_rd = 1'b0, // read
	output reg hung = 1'b0 // read not answered
);
	// released lines show the inverse so stale values cannot pass
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_addr <= ~a;
			reg_wdata <= ~d;
		end
	endtask
	task rd(input [7:0] a, output [7:0] d);
		integer n;
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			reg_addr <= ~a;
			n = 0;
			do begin
				@(posedge clk);
				n = n + 1;
			end while (reg_rvalid !== 1'b1 && n < 4);
			d = reg_rdata;
			hung = reg_rvalid !== 1'b1;
		end
	endtask
endmodule // dfa_host

// *** test/dfa_config_regs_tb.sv ***
// self-checking bench for the demod filter / afc config bank
`timescale 1ns/1ps
module dfa_config_regs_tb;
	reg clk, nrst, ask_mode, preamble_det, rx_restart;
	wire reg_wr, reg_rd, reg_rvalid, hung, low_delay_buffer_sel, filter_bandwidth_boost;
	wire low_delay_buffer_sel_conflict, lower_bound_conflict, threshold_method_sel, adaptive_peak_detector;
	wire precharged_lowpass, threshold_filter_bw, afc_enable, freeze_on_preamble;
	wire afc_frozen, afc_update_en;
	wire [7:0] reg_addr, reg_wdata, reg_rdata, threshold_lower_bound;
	wire [4:0] threshold_time_const, threshold_gain_const;
	wire [3:0] rate_large_shift, rate_small_denom, peak_hold_mult;
	wire [2:0] rate_conv_large_step, rate_conv_small_step, freq_offset_limit, loop_gain_shift;
	wire [1:0] peak_hold_time, freq_loop_gain;
	integer failures, tests_run, i;
	reg [7:0] d, v;
	localparam [39:0] BOUNDS = 40'h80FF00017F;
	dfa_config_regs DUT (.*);
	dfa_host h (.clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .hung);
	// ============================================================
	// helpers
	task chk(input [7:0] got, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task test_done;
		begin
			$display("tests_run %0d failures %0d", tests_run, failures);
			if (failures == 0 && tests_run > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task rchk(input [7:0] a, input [7:0] exp);
		begin
			h.rd(a, v);
			if (hung) begin
				failures = failures + 1;
				test_done;
			end else begin
				chk(v, exp);
			end
		end
	endtask
	task wr2(input [7:0] a, input [7:0] x);
		begin
			h.wr(a, x);
			repeat (2) @(posedge clk);
		end
	endtask
	task pd_pulse;
		begin
			@(posedge clk);
			preamble_det <= 1'b1;
			@(posedge clk);
			preamble_det <= 1'b0;
			@(posedge clk);
		end
	endtask
	// ============================================================
	// scenarios
	task t_reset;
		begin
			rchk(8'h03, 8'h10);
			rchk(8'h04, 8'h00);
			rchk(8'h05, 8'h10);
			rchk(8'h06, 8'h0F);
			rchk(8'h07, 8'h02);
			rchk(8'h08, 8'h00);
			rchk(8'h0C, 8'h00);
			chk({6'h0, afc_enable, afc_update_en}, 8'h00);
			$display("reset test done");
		end
	endtask
	task t_filter;
		begin
			for (i = 0; i < 64; i = i + 1) begin
				d = {i[0] ^ i[4], i[1], i[5:0]};
				wr2(8'h03, d);
				chk({4'h0, rate_large_shift}, {4'h0, 4'h2 - {1'b0, d[5:3]}});
				chk({4'h0, rate_small_denom}, 8'h08 + d[2:0]);
				v = {7'h0, d[7] & ~(d[5:3] > 3'h2 | (d[5:3] == 3'h2 & ~d[0]))};
				chk({7'h0, low_delay_buffer_sel_conflict}, v);
				chk({low_delay_buffer_sel, filter_bandwidth_boost, rate_conv_large_step, rate_conv_small_step}, d);
				rchk(8'h03, d);
			end
			$display("filter test done");
		end
	endtask
	task t_thresh;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				d = BOUNDS[i*8 +: 8];
				wr2(8'h04, d);
				chk({7'h0, lower_bound_conflict}, {7'h0, ~d[7] & |d});
				chk(threshold_lower_bound, d);
				rchk(8'h04, d);
			end
			// bit 7 set on purpose: it must not be stored
			for (i = 0; i < 4; i = i + 1) begin
				d = {1'b1, i[1:0], 5'h15 ^ i[4:0]};
				wr2(8'h05, d);
				chk({4'h0, peak_hold_mult}, 8'h01 << i);
				rchk(8'h05, {1'b0, d[6:0]});
				chk({1'b0, peak_hold_time, threshold_time_const}, {1'b0, d[6:0]});
				d = {1'b1, i[0], i[1], 5'h0A ^ i[4:0]};
				wr2(8'h06, d);
				chk({6'h0, adaptive_peak_detector, precharged_lowpass}, {6'h0, i[0], ~i[0]});
				chk({7'h0, threshold_filter_bw}, {7'h0, i[1]});
				chk({1'b0, threshold_method_sel, threshold_filter_bw, threshold_gain_const}, {1'b0, d[6:0]});
				rchk(8'h06, {1'b0, d[6:0]});
			end
			$display("threshold test done");
		end
	endtask
	task t_afc;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				d = {3'h7, i[2:0], i[1:0]};
				wr2(8'h07, d);
				chk({7'h0, afc_enable}, {7'h0, i != 0});
				chk({5'h0, loop_gain_shift}, {6'h0, i[1:0]});
				chk({3'h0, freq_offset_limit, freq_loop_gain}, {3'h0, d[4:0]});
				rchk(8'h07, {3'h0, d[4:0]});
			end
			wr2(8'h08, 8'h40);
			rchk(8'h08, 8'h40);
			chk({7'h0, freeze_on_preamble}, 8'h01);
			pd_pulse;
			chk({6'h0, afc_frozen, afc_update_en}, 8'h02);
			@(posedge clk);
			rx_restart <= 1'b1;
			@(posedge clk);
			rx_restart <= 1'b0;
			@(posedge clk);
			chk({6'h0, afc_frozen, afc_update_en}, 8'h01);
			pd_pulse;
			ask_mode <= 1'b1;
			pd_pulse;
			chk({7'h0, afc_frozen}, 8'h00);
			ask_mode <= 1'b0;
			wr2(8'h08, 8'h00);
			pd_pulse;
			chk({7'h0, afc_frozen}, 8'h00);
			$display("afc test done");
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		nrst = 1'b0;
		ask_mode = 1'b0;
		preamble_det = 1'b0;
		rx_restart = 1'b0;
		failures = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_reset;
		t_filter;
		t_thresh;
		t_afc;
		test_done;
	end
endmodule // dfa_config_regs_tb
